// File: core/sfr_pkg.sv
// Constants, opcodes and types shared by the security/mode/reset command logic
package sfr_pkg;

  // Opcodes
  localparam logic [7:0] OP_WREN       = 8'h06;
  localparam logic [7:0] OP_WRDI       = 8'h04;
  localparam logic [7:0] OP_PROG_SEC   = 8'h42;
  localparam logic [7:0] OP_READ_SEC   = 8'h48;
  localparam logic [7:0] OP_SET_PARAM  = 8'hc0;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_BURST_WRAP = 8'h0c;
  localparam logic [7:0] OP_SET_WRAP   = 8'h77;
  localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
  localparam logic [7:0] OP_EXIT_QUAD  = 8'hff;
  localparam logic [7:0] OP_RESET_EN   = 8'h66;
  localparam logic [7:0] OP_RESET      = 8'h99;

  // Frame layout
  localparam logic [5:0] OPCODE_BITS    = 6'h08;
  localparam logic [5:0] ADDR_BITS      = 6'h18;
  localparam logic [5:0] SEC_DUMMY_CLKS = 6'h08;
  localparam logic [5:0] WRAP_CMD_BITS  = 6'h18;

  // Security register address fields
  localparam int         SEL_LSB      = 12;
  localparam logic [3:0] SEC_SEL_LO   = 4'h1;
  localparam logic [3:0] SEC_SEL_HI   = 4'h3;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;

  // Parameter and wrap byte fields
  localparam int PARAM_DUMMY_LSB = 4;
  localparam int PARAM_WRAP_LSB  = 0;
  localparam int WSET_LSB        = 4;
  localparam int WLEN_LSB        = 4;

  // Reset values
  localparam logic [7:0] PARAM_RST     = 8'h00;
  localparam logic [1:0] WRAP_SEL_RST  = 2'h0;
  localparam logic [3:0] DUMMY_CLK_RST = 4'h2;
  localparam logic [2:0] WSET_RST      = 3'h0;

  // Software reset recovery time
  localparam int RST_TIME_NS   = 30000;
  localparam int CLK_PERIOD_NS = 8;
  localparam logic [11:0] RST_CYCLES =
    12'((RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA,
    PH_IGNORE
  } sfr_phase_type;

endpackage

// File: core/sfr_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module sfr_sync #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_chk
    $error("sfr_sync width must be positive");
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RESET_VAL;
      q      <= RESET_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// File: core/sfr_mem.sv
// Security register storage with registered read data
`timescale 1ns/1ns
module sfr_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 768,
  parameter int AW    = 10
) (
  // Clock
  input  wire logic             clk_sys,
  // Read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_chk
    $error("sfr_mem depth does not fit its address width");
  end

  // Parts leave the factory erased
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = {WIDTH{1'b1}};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// File: core/sfr_cmd.sv
// Security register, read parameter, quad mode and software reset command logic
`timescale 1ns/1ns
module sfr_cmd
  import sfr_pkg::*;
#(
  parameter int SEC_REGS  = 3,
  parameter int SEC_BYTES = 256
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out_q,
  output logic      [3:0]  io_oe_q,
  // Status from the rest of the device
  input  wire logic        busy,
  input  wire logic        quad_enable_bit,
  input  wire logic [2:0]  security_lock_bits,
  // Main array read port
  input  wire logic [7:0]  array_data,
  output logic      [23:0] array_addr_q,
  output logic             array_read_q,
  // Mode and settings
  output logic             quad_command_mode_q,
  output logic             write_enable_latch_q,
  output logic      [7:0]  read_parameter_field_q,
  output logic      [3:0]  dummy_clocks_q,
  output logic      [1:0]  wrap_length_select_q,
  output logic      [2:0]  wrap_setting_bits_q,
  // Software reset
  output logic             soft_reset_q,
  output logic             reset_busy_q
);
  import sfr_pkg::*;

  localparam int MEM_DEPTH = SEC_REGS * SEC_BYTES;

  if (SEC_BYTES != 256 || SEC_REGS < 1 || SEC_REGS > 3) begin : g_chk
    $error("sfr_cmd serves up to three 256-byte security registers");
  end

  function automatic logic [23:0] wrap_inc(input logic [23:0] a, input logic [23:0] m);
    return (a & ~m) | ((a + 24'h1) & m);
  endfunction

  function automatic logic [23:0] wrap_mask(input logic [1:0] sel);
    return (24'h8 << sel) - 24'h1;
  endfunction

  function automatic logic sec_valid(input logic [23:0] a);
    return a[23:16] == 8'h00 && a[11:8] == 4'h0 &&
           a[15:12] >= SEC_SEL_LO && a[15:12] <= SEC_SEL_HI;
  endfunction

  // Register number 1..3 becomes 0..2; code 3 only reachable with a bad address
  function automatic logic [1:0] sec_reg(input logic [23:0] a);
    return a[SEL_LSB+1:SEL_LSB] - 2'h1;
  endfunction

  function automatic logic [9:0] sec_index(input logic [23:0] a);
    return {sec_reg(a), a[7:0]};
  endfunction

  // Synchronised pins
  logic [5:0]    pins_s;
  logic          sclk_d_q;
  logic          pin_cs;
  logic          pin_sclk;
  logic [3:0]    pin_io;

  // Frame state
  sfr_phase_type ph_q;
  logic [7:0]    op_q;
  logic [23:0]   addr_q;
  logic [31:0]   sh_q;
  logic [5:0]    bcnt_q;
  logic          rst_en_q;
  logic          prog_wrote_q;
  logic [11:0]   rst_cnt_q;
  logic [7:0]    tx_q;
  logic [2:0]    fcnt_q;

  // Memory port
  logic [7:0]    mem_rdata;
  logic          mem_we_q;
  logic [9:0]    mem_waddr_q;
  logic [7:0]    mem_wdata_q;

  // Decode helpers
  logic          rise;
  logic          fall;
  logic [2:0]    bpc;
  logic [31:0]   sh_nx;
  logic [5:0]    bcnt_nx;
  logic          byte_done;
  logic [7:0]    op_nx;
  logic          op_done;
  logic          accept_reset;
  logic          is_read;
  logic          rd_phase;
  logic          load_byte;
  logic          prog_byte;
  logic          locked_now;
  logic [5:0]    dummy_need;
  logic [23:0]   rd_next;
  logic [7:0]    ld_byte;

  sfr_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h20)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({cs_n, sclk, io_in}),
    .q       (pins_s)
  );

  assign pin_cs   = pins_s[5];
  assign pin_sclk = pins_s[4];
  assign pin_io   = pins_s[3:0];

  sfr_mem #(
    .WIDTH (8),
    .DEPTH (MEM_DEPTH),
    .AW    (10)
  ) u_mem (
    .clk_sys (clk_sys),
    .raddr   (sec_index(addr_q)),
    .rdata_q (mem_rdata),
    .we      (mem_we_q),
    .waddr   (mem_waddr_q),
    .wdata   (mem_wdata_q)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_q <= 1'b0;
    end else begin
      sclk_d_q <= pin_sclk;
    end
  end

  always_comb begin
    rise       = !pin_cs && pin_sclk && !sclk_d_q;
    fall       = !pin_cs && !pin_sclk && sclk_d_q;
    bpc        = quad_command_mode_q ? 3'h4 : 3'h1;
    sh_nx      = quad_command_mode_q ? {sh_q[27:0], pin_io} : {sh_q[30:0], pin_io[0]};
    bcnt_nx    = bcnt_q + {3'h0, bpc};
    byte_done  = bcnt_nx == OPCODE_BITS;
    op_nx      = sh_nx[7:0];
    op_done    = rise && ph_q == PH_OPCODE && byte_done;
    accept_reset = op_done && op_nx == OP_RESET && rst_en_q;
    is_read    = op_q == OP_READ_SEC || op_q == OP_FAST_READ || op_q == OP_BURST_WRAP;
    rd_phase   = !pin_cs && ph_q == PH_DATA && is_read;
    load_byte  = fall && rd_phase && fcnt_q == 3'h0;
    prog_byte  = rise && ph_q == PH_DATA && op_q == OP_PROG_SEC && byte_done;
    locked_now = security_lock_bits[sec_reg(addr_q)];
    dummy_need = op_q == OP_READ_SEC ? SEC_DUMMY_CLKS : {2'h0, dummy_clocks_q};
    ld_byte    = quad_command_mode_q ? array_data : mem_rdata;
    unique case (op_q)
      OP_READ_SEC:   rd_next = wrap_inc(addr_q, 24'h0000ff);
      OP_BURST_WRAP: rd_next = wrap_inc(addr_q, wrap_mask(wrap_length_select_q));
      default:       rd_next = addr_q + 24'h1;
    endcase
  end

  // Command decode, frame sequencing and settings
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_q                   <= PH_OPCODE;
      op_q                   <= 8'h00;
      addr_q                 <= 24'h000000;
      sh_q                   <= 32'h00000000;
      bcnt_q                 <= 6'h00;
      rst_en_q               <= 1'b0;
      prog_wrote_q           <= 1'b0;
      quad_command_mode_q    <= 1'b0;
      write_enable_latch_q   <= 1'b0;
      read_parameter_field_q <= PARAM_RST;
      dummy_clocks_q         <= DUMMY_CLK_RST;
      wrap_length_select_q   <= WRAP_SEL_RST;
      wrap_setting_bits_q    <= WSET_RST;
    end else if (reset_busy_q) begin
      ph_q <= PH_IGNORE;
    end else if (pin_cs) begin
      ph_q         <= PH_OPCODE;
      bcnt_q       <= 6'h00;
      prog_wrote_q <= 1'b0;
      // Latch clears only when chip select rises after a whole byte; each byte is written as it completes
      if (prog_wrote_q) begin
        write_enable_latch_q <= 1'b0;
      end
    end else if (rise) begin
      sh_q   <= sh_nx;
      bcnt_q <= bcnt_nx;
      unique case (ph_q)
        PH_OPCODE: if (byte_done) begin
          op_q     <= op_nx;
          bcnt_q   <= 6'h00;
          ph_q     <= PH_IGNORE;
          rst_en_q <= op_nx == OP_RESET_EN;
          if (accept_reset) begin
            // Power-on state; the latch, quad mode and wrap all drop here
            write_enable_latch_q   <= 1'b0;
            quad_command_mode_q    <= 1'b0;
            read_parameter_field_q <= PARAM_RST;
            dummy_clocks_q         <= DUMMY_CLK_RST;
            wrap_length_select_q   <= WRAP_SEL_RST;
            wrap_setting_bits_q    <= WSET_RST;
          end else if (!quad_command_mode_q) begin
            if (op_nx == OP_WREN) begin
              write_enable_latch_q <= 1'b1;
            end
            if (op_nx == OP_WRDI) begin
              write_enable_latch_q <= 1'b0;
            end
            if (op_nx == OP_ENTER_QUAD && quad_enable_bit) begin
              quad_command_mode_q <= 1'b1;
            end
            if ((op_nx == OP_PROG_SEC && write_enable_latch_q && !busy) ||
                (op_nx == OP_READ_SEC && !busy) ||
                op_nx == OP_SET_WRAP) begin
              ph_q <= PH_ADDR;
            end
          end else begin
            if (op_nx == OP_WREN) begin
              write_enable_latch_q <= 1'b1;
            end
            if (op_nx == OP_EXIT_QUAD) begin
              quad_command_mode_q <= 1'b0;
            end
            if (op_nx == OP_SET_PARAM) begin
              ph_q <= PH_DATA;
            end
            if (op_nx == OP_FAST_READ || op_nx == OP_BURST_WRAP) begin
              ph_q <= PH_ADDR;
            end
          end
        end
        PH_ADDR: if (bcnt_nx == ADDR_BITS) begin
          addr_q <= sh_nx[23:0];
          bcnt_q <= 6'h00;
          if (op_q == OP_SET_WRAP) begin
            ph_q <= PH_DATA;
          end else if (op_q != OP_PROG_SEC && op_q != OP_READ_SEC) begin
            ph_q <= PH_DUMMY;
          end else if (!sec_valid(sh_nx[23:0])) begin
            ph_q <= PH_IGNORE;
          end else if (op_q == OP_READ_SEC) begin
            ph_q <= PH_DUMMY;
          end else if (security_lock_bits[sec_reg(sh_nx[23:0])]) begin
            ph_q <= PH_IGNORE;
          end else begin
            ph_q <= PH_DATA;
          end
        end
        PH_DUMMY: begin
          bcnt_q <= bcnt_q + 6'h01;
          if (bcnt_q + 6'h01 == dummy_need) begin
            ph_q   <= PH_DATA;
            bcnt_q <= 6'h00;
          end
        end
        PH_DATA: if (byte_done && !is_read) begin
          bcnt_q <= 6'h00;
          unique case (op_q)
            OP_PROG_SEC: begin
              addr_q       <= wrap_inc(addr_q, 24'h0000ff);
              prog_wrote_q <= 1'b1;
            end
            OP_SET_PARAM: begin
              read_parameter_field_q <= op_nx;
              dummy_clocks_q <= 4'h2 + {op_nx[PARAM_DUMMY_LSB+1:PARAM_DUMMY_LSB], 1'b0};
              wrap_length_select_q <= op_nx[PARAM_WRAP_LSB+1:PARAM_WRAP_LSB];
              ph_q <= PH_IGNORE;
            end
            default: begin
              wrap_setting_bits_q  <= op_nx[WSET_LSB+2:WSET_LSB];
              wrap_length_select_q <= op_nx[WLEN_LSB+1:WLEN_LSB];
              ph_q <= PH_IGNORE;
            end
          endcase
        end
        default: ;
      endcase
    end else if (load_byte) begin
      addr_q <= rd_next;
    end
  end

  // Security register write, one byte at a time, bits can only clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_q    <= 1'b0;
      mem_waddr_q <= 10'h000;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_we_q    <= prog_byte && !reset_busy_q;
      mem_waddr_q <= sec_index(addr_q);
      mem_wdata_q <= op_nx & mem_rdata;
    end
  end

  // Output shifter, data changes only on falling clock edges; enables drop as soon as the read phase ends
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_out_q <= 4'h0;
      io_oe_q  <= 4'h0;
      tx_q     <= 8'h00;
      fcnt_q   <= 3'h0;
    end else if (!rd_phase || reset_busy_q) begin
      io_oe_q <= 4'h0;
      fcnt_q  <= 3'h0;
    end else if (fall) begin
      fcnt_q <= fcnt_q + bpc;
      if (quad_command_mode_q) begin
        io_oe_q <= 4'hf;
        io_out_q <= load_byte ? ld_byte[7:4] : tx_q[7:4];
        tx_q <= load_byte ? {ld_byte[3:0], 4'h0} : {tx_q[3:0], 4'h0};
      end else begin
        io_oe_q <= 4'h2;
        io_out_q <= {2'h0, load_byte ? ld_byte[7] : tx_q[7], 1'b0};
        tx_q <= load_byte ? {ld_byte[6:0], 1'b0} : {tx_q[6:0], 1'b0};
      end
    end
  end

  // Main array read request
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      array_addr_q <= 24'h000000;
      array_read_q <= 1'b0;
    end else begin
      array_addr_q <= addr_q;
      array_read_q <= rd_phase && quad_command_mode_q;
    end
  end

  // Software reset pulse and recovery window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset_q <= 1'b0;
      reset_busy_q <= 1'b0;
      rst_cnt_q    <= 12'h000;
    end else begin
      soft_reset_q <= accept_reset && !reset_busy_q;
      if (accept_reset && !reset_busy_q) begin
        rst_cnt_q    <= RST_CYCLES;
        reset_busy_q <= 1'b1;
      end else if (rst_cnt_q != 12'h000) begin
        rst_cnt_q    <= rst_cnt_q - 12'h001;
        reset_busy_q <= rst_cnt_q != 12'h001;
      end
    end
  end

  property p_prog_wel;
    @(posedge clk_sys) disable iff (!rst_n)
      mem_we_q |-> $past(write_enable_latch_q) && $past(ph_q) == PH_DATA;
  endproperty
  a_prog_wel: assert property (p_prog_wel) else $error("program without latch");

  property p_prog_lock;
    @(posedge clk_sys) disable iff (!rst_n)
      mem_we_q |-> !$past(locked_now);
  endproperty
  a_prog_lock: assert property (p_prog_lock) else $error("locked register written");

  property p_prog_clear_only;
    @(posedge clk_sys) disable iff (!rst_n)
      mem_we_q |-> (mem_wdata_q & ~$past(mem_rdata)) == 8'h00;
  endproperty
  a_prog_clear_only: assert property (p_prog_clear_only) else $error("bit set");

  property p_param_quad;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(read_parameter_field_q) && !soft_reset_q |-> $past(quad_command_mode_q);
  endproperty
  a_param_quad: assert property (p_param_quad) else $error("params set in SPI");

  property p_reset_defaults;
    @(posedge clk_sys) disable iff (!rst_n)
      soft_reset_q |-> wrap_length_select_q == 2'h0 && dummy_clocks_q == 4'h2
                       && !write_enable_latch_q;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad defaults");

  property p_reset_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      soft_reset_q |-> reset_busy_q [*8] ##1 (ph_q == PH_IGNORE);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset window short");

  property p_quad_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(quad_command_mode_q) |-> $past(quad_enable_bit) && $past(op_nx) == OP_ENTER_QUAD;
  endproperty
  a_quad_entry: assert property (p_quad_entry) else $error("quad entry w/o enable");

  property p_mode_keeps;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(quad_command_mode_q) && !soft_reset_q |->
        $stable(write_enable_latch_q) && $stable(wrap_length_select_q);
  endproperty
  a_mode_keeps: assert property (p_mode_keeps) else $error("mode change lost state");

  property p_read_busy;
    @(posedge clk_sys) disable iff (!rst_n)
      op_done && op_nx == OP_READ_SEC && busy && !reset_busy_q |=> ph_q == PH_IGNORE;
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("read taken while busy");

  property p_read_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      load_byte && op_q == OP_READ_SEC && !reset_busy_q |=>
        addr_q[23:8] == $past(addr_q[23:8]) && addr_q[7:0] == $past(addr_q[7:0]) + 8'h01;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read address step");

endmodule

// File: dv/sfr_host.sv
// Host flash controller model driving the serial pins
`timescale 1ns/1ns
module sfr_host (
  // Clock
  input  wire logic       clk_sys,
  // Serial pins
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out_q,
  input  wire logic [3:0] io_oe_q,
  // Read results
  output logic            rx_stb,
  output logic [7:0]      rx_byte,
  output logic            oe_seen
);
  logic quad;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'h0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
    oe_seen = 1'b0;
    quad = 1'b0;
  end
  // Low phase 5 system clocks, high phase 4 plus the wait for the next clock; answer lands 2-3 after the fall
  task automatic clk_one(input logic [3:0] d, input logic drv, output logic [3:0] s);
    @(negedge clk_sys);
    sclk = 1'b0;
    io_in = drv ? d : ~io_in;  // Released lines toggle so stale data never passes
    repeat (5) @(negedge clk_sys);
    s = (io_out_q & io_oe_q) | ~io_oe_q;  // Undriven lines float high on pull-ups
    oe_seen = oe_seen | (|io_oe_q);
    sclk = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    logic [3:0] s;
    rx = 8'h00;
    if (quad) begin
      clk_one(tx[7:4], drv, s);
      rx[7:4] = s;
      clk_one(tx[3:0], drv, s);
      rx[3:0] = s;
    end else begin
      for (int i = 7; i >= 0; i--) begin
        clk_one({3'h0, tx[i]}, drv, s);
        rx[i] = s[1];
      end
    end
  endtask
  // One whole command per chip-select frame, MSB first
  task automatic run(input logic [7:0] tx[$], input int n);
    logic [7:0] r;
    oe_seen = 1'b0;
    @(negedge clk_sys);
    cs_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    foreach (tx[i]) xbyte(tx[i], 1'b1, r);
    repeat (n) begin
      xbyte(8'h00, 1'b0, r);
      rx_byte = r;
      rx_stb = 1'b1;
      @(negedge clk_sys);
      rx_stb = 1'b0;
    end
    sclk = 1'b0;
    @(negedge clk_sys);
    cs_n = 1'b1;
    io_in = ~io_in;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// File: dv/test_flash_security_mode_reset_cmds.sv
// Self-checking bench for the security, mode and reset command logic
`timescale 1ns/1ns
module test_flash_security_mode_reset_cmds;
  import sfr_pkg::*;
  logic        clk_sys, rst_n, cs_n, sclk, busy, quad_enable_bit, rx_stb, oe_seen;
  logic        array_read_q, quad_command_mode_q, write_enable_latch_q;
  logic        soft_reset_q, reset_busy_q;
  logic [3:0]  io_in, io_out_q, io_oe_q, dummy_clocks_q;
  logic [2:0]  security_lock_bits, wrap_setting_bits_q;
  logic [1:0]  wrap_length_select_q;
  logic [7:0]  array_data, read_parameter_field_q, rx_byte, a, b0, b1;
  logic [23:0] array_addr_q;
  logic [7:0]  exp_q[$];
  int          bad_count, checked, rst_seen, arr_seen;

  sfr_cmd u_sfr_cmd (.clk_sys, .rst_n, .cs_n, .sclk, .io_in, .io_out_q, .io_oe_q, .busy,
    .quad_enable_bit, .security_lock_bits, .array_data, .array_addr_q, .array_read_q,
    .quad_command_mode_q, .write_enable_latch_q, .read_parameter_field_q, .dummy_clocks_q,
    .wrap_length_select_q, .wrap_setting_bits_q, .soft_reset_q, .reset_busy_q);
  sfr_host u_sfr_host (.clk_sys, .cs_n, .sclk, .io_in, .io_out_q, .io_oe_q, .rx_stb,
    .rx_byte, .oe_seen);

  // Main array stand-in with a pattern tied to the address
  assign array_data = array_addr_q[7:0] ^ 8'h5a;

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic go(input logic [7:0] tx[$], input int n);
    u_sfr_host.run(tx, n);
  endtask
  task automatic rd(input logic [15:0] ad, input int n);
    go({OP_READ_SEC, 8'h00, ad[15:8], ad[7:0], 8'h00}, n);
  endtask
  task automatic prog(input logic [15:0] ad, input logic [7:0] d);
    go({OP_WREN}, 0);
    go({OP_PROG_SEC, 8'h00, ad[15:8], ad[7:0], d}, 0);
  endtask

  // Results are compared in arrival order against the notes
  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) check("extra byte", 8'h01, 8'h00);
    else check("read byte", rx_byte, exp_q.pop_front());
  end
  always @(posedge clk_sys) if (soft_reset_q === 1'b1) rst_seen++;
  always @(posedge clk_sys) if (array_read_q === 1'b1) arr_seen++;

  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end

  initial begin
    {rst_n, busy, quad_enable_bit, security_lock_bits} = '0;
    {bad_count, checked, rst_seen, arr_seen} = '0;
    void'($urandom(5));
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("dummy", 8'(dummy_clocks_q), 8'h02);
    check("quad", 8'(quad_command_mode_q), 8'h00);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    go({OP_WREN}, 0);
    go({OP_PROG_SEC, 8'h00, 8'h10, 8'hfe, b0, b1}, 0);
    prog(16'h1000, 8'h3c);
    exp_q = {b0, b1, 8'h3c, 8'hff};
    rd(16'h10fe, 4);
    check("read drive", 8'(oe_seen), 8'h01);
    go({OP_PROG_SEC, 8'h00, 8'h20, 8'h00, 8'h00}, 0);
    security_lock_bits = 3'h4;
    prog(16'h3000, 8'h00);
    exp_q = {8'hff, 8'hff};
    rd(16'h2000, 1);
    rd(16'h3000, 1);
    busy = 1'b1;
    go({OP_READ_SEC, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, 0);
    check("busy read drive", 8'(oe_seen), 8'h00);
    busy = 1'b0;
    go({OP_SET_PARAM, 8'h33}, 0);
    check("spi param", read_parameter_field_q, 8'h00);
    go({OP_SET_WRAP, 8'h00, 8'h00, 8'h00, 8'h20}, 0);
    check("wrap bits", 8'(wrap_setting_bits_q), 8'h02);
    go({OP_ENTER_QUAD}, 0);
    check("quad off", 8'(quad_command_mode_q), 8'h00);
    quad_enable_bit = 1'b1;
    go({OP_WREN}, 0);
    go({OP_ENTER_QUAD}, 0);
    u_sfr_host.quad = 1'b1;
    check("quad on", 8'(quad_command_mode_q), 8'h01);
    check("wrap kept", 8'(wrap_length_select_q), 8'h02);
    check("latch kept", 8'(write_enable_latch_q), 8'h01);
    for (int c = 3; c >= 0; c--) begin
      go({OP_SET_PARAM, 8'(c * 17)}, 0);
      check("dummy code", 8'(dummy_clocks_q), 8'(2 + 2 * c));
      check("wrap code", 8'(wrap_length_select_q), 8'(c));
    end
    go({OP_SET_PARAM, 8'h01}, 0);
    check("no array read", 8'(arr_seen), 8'h00);
    a = 8'($urandom);
    for (int k = 0; k < 20; k++) exp_q.push_back({a[7:4], 4'(a[3:0] + k)} ^ 8'h5a);
    go({OP_BURST_WRAP, 8'h00, 8'h00, a, 8'h00}, 20);
    check("array read", 8'(arr_seen != 0), 8'h01);
    go({OP_RESET_EN}, 0);
    go({OP_WREN}, 0);
    go({OP_RESET}, 0);
    check("reset cancelled", 8'(rst_seen), 8'h00);
    go({OP_EXIT_QUAD}, 0);
    u_sfr_host.quad = 1'b0;
    check("spi back", 8'(quad_command_mode_q), 8'h00);
    check("wrap after exit", 8'(wrap_length_select_q), 8'h01);
    check("latch after exit", 8'(write_enable_latch_q), 8'h01);
    go({OP_RESET_EN}, 0);
    go({OP_RESET}, 0);
    check("reset pulse", 8'(rst_seen), 8'h01);
    check("recovering", 8'(reset_busy_q), 8'h01);
    check("latch cleared", 8'(write_enable_latch_q), 8'h00);
    check("param cleared", read_parameter_field_q, 8'h00);
    check("wrap bits cleared", 8'(wrap_setting_bits_q), 8'h00);
    check("wrap default", 8'(wrap_length_select_q), 8'h00);
    check("dummy default", 8'(dummy_clocks_q), 8'h02);
    go({OP_WREN}, 0);
    check("no cmd in reset", 8'(write_enable_latch_q), 8'h00);
    for (int w = 0; w < 5000 && reset_busy_q !== 1'b0; w++) @(negedge clk_sys);
    go({OP_WREN}, 0);
    check("cmd after reset", 8'(write_enable_latch_q), 8'h01);
    check("queue empty", 8'(exp_q.size()), 8'h00);
    final_report();
  end
endmodule
